// [testbench/fan_valve_model.sv]
`timescale 1ns/100ps
module fan_valve_model
   import fan_pkg::*;
(
   // Clock
   input wire logic sys_clk_in,
   // Valve commands
   input wire norm_t prop_cmd_in,
   input wire logic rev_cmd_in,
   // Direction shifts made under flow
   output int unsafe_count_out
);
   logic rev_q = 1'b0;
   int count_q = 0;

   // Shifting the spool with oil flowing would shock the motor
   always @(posedge sys_clk_in) begin
      rev_q <= rev_cmd_in;
      if (rev_q !== rev_cmd_in && prop_cmd_in !== 16'h0000) begin
         count_q <= count_q + 1;
      end
   end
   assign unsafe_count_out = count_q;
endmodule

// [testbench/hydraulic_fan_valve_control_asserts.sv]
`timescale 1ns/100ps
`include "fan_cfg.svh"
module fan_ctrl_checker
   import fan_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 10
)
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Sources
   input wire logic [`N_SRC-1:0][`NORM_W-1:0] src_value_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   // Valve commands
   input wire norm_t prop_cmd_out,
   input wire logic rev_cmd_out
);
   src_cfg_t stop_cfg_q;
   logic [3:0] stop_idx;
   logic [15:0] stop_val;
   logic stop_act;

   // Shadow of the stop input selection, so the checker knows when it acts
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stop_cfg_q <= 5'h00;
      end else if (reg_wr_in && reg_addr_in == 8'h06) begin
         stop_cfg_q <= reg_wdata_in[4:0];
      end
   end

   // Selected stop value after inversion; sources 9..15 mean none
   assign stop_idx = stop_cfg_q[3:0] - 4'h1;
   assign stop_val = src_value_in[stop_idx[2:0]] ^ {16{stop_cfg_q[4]}};
   assign stop_act = (stop_cfg_q[3:0] != 4'h0) && (stop_cfg_q[3:0] <= 4'h8)
      && stop_val[15];

   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_wr(logic [7:0] a);
      reg_wr_in && reg_addr_in == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      reg_rd_in && reg_addr_in == a;
   endsequence

   a_rdata_quiet: assert property (!$past(reg_rd_in) |->
      reg_rdata_out == 32'h0) else $error("read data outside read slot");
   a_unmapped_zero: assert property (s_rd(8'hFF) |=>
      reg_rdata_out == 32'h0) else $error("unmapped read not zero");
   a_timer_rw: assert property (s_wr(8'h20) ##1 s_rd(8'h20) |=>
      reg_rdata_out == {16'h0000, $past(reg_wdata_in[15:0], 2)})
      else $error("stop time readback wrong");
   a_cfg_rw: assert property (s_wr(8'h06) ##1 s_rd(8'h06) |=>
      reg_rdata_out == {27'h0, $past(reg_wdata_in[4:0], 2)})
      else $error("config readback wrong");
   a_status_mirror: assert property (s_rd(8'h30) |=>
      reg_rdata_out[16] == $past(rev_cmd_out)
      && reg_rdata_out[15:0] == $past(prop_cmd_out))
      else $error("status disagrees with outputs");
   a_stop_idle: assert property (stop_act [*3] |=>
      prop_cmd_out == 16'h0000 && !rev_cmd_out)
      else $error("stop did not idle the valves");
   a_rev_rise_closed: assert property ($rose(rev_cmd_out) |->
      prop_cmd_out == 16'h0000 && $past(prop_cmd_out) == 16'h0000)
      else $error("reverse switched with valve open");
   a_rev_fall_closed: assert property ($fell(rev_cmd_out) |->
      prop_cmd_out == 16'h0000
      && ($past(prop_cmd_out) == 16'h0000 || $past(stop_act, 2)))
      else $error("reverse released with valve open");
endmodule

bind hydraulic_fan_valve_control fan_ctrl_checker #(
   .TICK_CYCLES(TICK_CYCLES)
) u_checker (
   .sys_clk_in(sys_clk_in),
   .reset_n_in(reset_n_in),
   .src_value_in(src_value_in),
   .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out),
   .prop_cmd_out(prop_cmd_out),
   .rev_cmd_out(rev_cmd_out)
);

// [testbench/hydraulic_fan_valve_control_test.sv]
`timescale 1ns/100ps
`include "fan_cfg.svh"
module hydraulic_fan_valve_control_test import fan_pkg::*;;
   logic sys_clk_in;
   logic reset_n_in;
   logic [`N_SRC-1:0][`NORM_W-1:0] src_value_in;
   logic [7:0] reg_addr_in;
   logic [31:0] reg_wdata_in;
   logic reg_wr_in;
   logic reg_rd_in;
   logic [31:0] reg_rdata_out;
   norm_t prop_cmd_out;
   logic rev_cmd_out;
   int unsafe_count;
   int fail_count;
   int n_checks;
   int n;
   logic [31:0] r;

   // Short tick keeps the sequence waits to tens of cycles
   hydraulic_fan_valve_control #(.TICK_CYCLES(10)) dut (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .src_value_in(src_value_in),
      .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out),
      .prop_cmd_out(prop_cmd_out),
      .rev_cmd_out(rev_cmd_out)
   );

   fan_valve_model valves (
      .sys_clk_in(sys_clk_in),
      .prop_cmd_in(prop_cmd_out),
      .rev_cmd_in(rev_cmd_out),
      .unsafe_count_out(unsafe_count)
   );

   // 100 MHz clock
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      #1 r = reg_rdata_out;
   endtask

   // Write then read back at once, with no gap between strobes
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      #1 r = reg_rdata_out;
   endtask

   task automatic src(input int i, input logic [15:0] v, input int k);
      @(posedge sys_clk_in);
      src_value_in[i] <= v;
      repeat (k) @(posedge sys_clk_in);
      #1;
   endtask

   // Bounded wait for the reverse valve; n holds the cycles spent
   task automatic wait_rev(input logic v, input int lim);
      n = 0;
      while (rev_cmd_out !== v && n < lim) begin
         @(posedge sys_clk_in);
         #1 n++;
      end
      if (rev_cmd_out !== v) begin
         $display("mismatch at %0t: got %h expected %h", $time,
            rev_cmd_out, v);
         fail_count++;
         stop_test();
      end
   endtask

   task automatic test_defaults();
      logic [7:0] a [10] = '{8'h00, 8'h04, 8'h06, 8'h10, 8'h11, 8'h12,
         8'h13, 8'h20, 8'h21, 8'h22};
      logic [31:0] e [10] = '{32'h0, 32'h0, 32'h0, 32'h4B0, 32'h3E8,
         32'h320, 32'hC8, 32'h32, 32'h5, 32'h64};
      for (int i = 0; i < 10; i++) begin
         rd(a[i]);
         check(r, e[i]);
      end
      rd(8'hFF);
      check(r, 32'h0);
      wr_rd(8'h30, 32'hFFFF_FFFF);
      check(r, 32'h0010_0000);
   endtask

   task automatic test_demand();
      // Last channel gets a lower high and a negative minimum, still ordered
      wr_rd(8'h1D, 32'h384);
      check(r, 32'h384);
      wr_rd(8'h1F, 32'hFC18);
      check(r, 32'hFFFF_FC18);
      // Every channel alone, override included, at both ends of scale
      for (int c = 0; c < 5; c++) begin
         wr_rd(8'(c), 32'(c + 1));
         src(c, 16'hFFFF, 8);
         check(prop_cmd_out, 16'hFFFF);
         src(c, 16'h0000, 8);
         check(prop_cmd_out, 16'h0000);
         wr_rd(8'(c), 32'h0);
      end
      wr_rd(8'h00, 32'h1);
      src(0, 16'hB334, 8);
      check(prop_cmd_out, 16'h7FFF);
      rd(8'h34);
      check(r, 32'h7FFF);
      wr_rd(8'h01, 32'h2);
      src(1, 16'hFFFF, 8);
      check(prop_cmd_out, 16'hFFFF);
      wr_rd(8'h01, 32'h12);
      check(r, 32'h12);
      src(1, 16'hFFFF, 8);
      check(prop_cmd_out, 16'h7FFF);
      wr_rd(8'h00, 32'h9);
      src(0, 16'hFFFF, 8);
      check(prop_cmd_out, 16'h0000);
      wr_rd(8'h01, 32'h0);
      wr_rd(8'h00, 32'h1);
      src(0, 16'hFFFF, 8);
      check(prop_cmd_out, 16'hFFFF);
   endtask

   task automatic test_reverse();
      wr_rd(8'h20, 32'h2);
      wr_rd(8'h21, 32'h1);
      wr_rd(8'h22, 32'h3);
      check(r, 32'h3);
      wr_rd(8'h05, 32'h3);
      src(2, 16'h8000, 3);
      check(prop_cmd_out, 16'h0000);
      wait_rev(1'b1, 60);
      check(32'(n >= 6), 32'h1);
      check(prop_cmd_out, 16'h0000);
      rd(8'h30);
      check(32'(r[16]), 32'h1);
      n = 0;
      while (prop_cmd_out === 16'h0000 && n < 40) begin
         @(posedge sys_clk_in);
         #1 n++;
      end
      check(prop_cmd_out, 16'hFFFF);
      src(2, 16'h0000, 0);
      wait_rev(1'b0, 120);
      check(32'(n >= 18), 32'h1);
      check(prop_cmd_out, 16'h0000);
   endtask

   task automatic test_stop();
      wr_rd(8'h06, 32'h15);
      src(4, 16'hFFFF, 0);
      src(2, 16'h8000, 0);
      wait_rev(1'b1, 60);
      src(4, 16'h0000, 4);
      check(prop_cmd_out, 16'h0000);
      check(32'(rev_cmd_out), 32'h0);
      src(4, 16'h0000, 30);
      check(32'(rev_cmd_out), 32'h0);
      src(2, 16'h0000, 0);
      src(4, 16'hFFFF, 12);
      check(prop_cmd_out, 16'hFFFF);
   endtask

   // Reset, then each scenario in turn
   initial begin
      reset_n_in = 1'b0;
      src_value_in = '0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 32'h0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      fail_count = 0;
      n_checks = 0;
      repeat (10) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      test_defaults();
      test_demand();
      test_reverse();
      test_stop();
      check(32'(unsafe_count), 32'h0);
      stop_test();
   end
endmodule

// [verilog/fan_cfg.svh]
`ifndef FAN_CFG_SVH
`define FAN_CFG_SVH

// Channel counts and normalized signal width
`define N_TEMP 4
`define N_SRC 8
`define NORM_W 16
`define NORM_FULL 16'hFFFF
`define NORM_ZERO 16'h0000

// Input configuration word: source select and inversion
`define CFG_W 5
`define CFG_SRC_LSB 0
`define CFG_SRC_W 4
`define CFG_INV_BIT 4
`define CFG_RESET 5'h00
`define N_CFG 7
`define CFG_IDX_OVR 3'h4
`define CFG_IDX_REV 3'h5
`define CFG_IDX_STOP 3'h6

// Register addresses
`define ADDR_CFG_BASE 8'h00
`define ADDR_SP_BASE 8'h10
`define ADDR_T_STOP 8'h20
`define ADDR_T_SWITCH 8'h21
`define ADDR_T_HOLD 8'h22
`define ADDR_STATUS 8'h30
`define ADDR_DEMAND_BASE 8'h34

// Setpoint slot within a channel group of four
`define SP_TMAX 2'h0
`define SP_THIGH 2'h1
`define SP_TLOW 2'h2
`define SP_TMIN 2'h3

// Setpoint reset values, tenths of a degree
`define TMAX_RESET 16'h04B0
`define THIGH_RESET 16'h03E8
`define TLOW_RESET 16'h0320
`define TMIN_RESET 16'h00C8

// Sequence times, tenths of a second
`define T_STOP_RESET 16'h0032
`define T_SWITCH_RESET 16'h0005
`define T_HOLD_RESET 16'h0064

// Status word layout
`define ST_CMD_LSB 0
`define ST_REV_BIT 16
`define ST_STATE_LSB 20

// Timebase: one tick per tenth of a second
`define TICK_TIME_NS 100000000
`define CLK_PERIOD_NS 10
`define TICK_CNT_W 24

`endif

// [verilog/fan_channel.sv]
`timescale 1ns/100ps
`include "fan_cfg.svh"

module fan_channel
   import fan_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Selected input
   input wire norm_t norm_in,
   input wire logic conn_in,
   // Setpoints
   input wire temp_t t_max_in,
   input wire temp_t t_high_in,
   input wire temp_t t_low_in,
   input wire temp_t t_min_in,
   // Speed demand
   output norm_t demand_out
);

   logic signed [16:0] span;
   logic signed [33:0] prod;
   logic signed [16:0] temp_d;
   logic signed [16:0] temp_q;
   logic conn_q;
   logic [16:0] over;
   logic [16:0] window;
   logic [32:0] quot;
   norm_t demand_q;

   // Scale the normalized input onto the min..max temperature span
   assign span = 17'(t_max_in) - 17'(t_min_in);
   assign prod = $signed({1'b0, norm_in}) * span;
   assign temp_d = 17'(t_min_in) + 17'(prod >>> 16);

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         temp_q <= 17'h00000;
         conn_q <= 1'b0;
      end else begin
         temp_q <= temp_d;
         conn_q <= conn_in;
      end
   end

   // Linear speed window between low and high temperature
   assign over = 17'(temp_q - 17'(t_low_in));
   assign window = 17'(17'(t_high_in) - 17'(t_low_in));
   assign quot = ({over, 16'h0000} - 33'(over)) / 33'(window);

   // Demand register; a closed window is treated as full demand
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         demand_q <= `NORM_ZERO;
      end else if (!conn_q) begin
         demand_q <= `NORM_ZERO;
      end else if (temp_q >= 17'(t_high_in) || window == 17'h00000) begin
         demand_q <= `NORM_FULL;
      end else if (temp_q <= 17'(t_low_in)) begin
         demand_q <= `NORM_ZERO;
      end else begin
         demand_q <= quot[15:0];
      end
   end

   assign demand_out = demand_q;

endmodule

// [verilog/fan_pkg.sv]
package fan_pkg;

   typedef logic [15:0] norm_t;
   typedef logic signed [15:0] temp_t;
   typedef logic [4:0] src_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FORWARD,
      ST_REV_STOP,
      ST_REV_SWITCH,
      ST_REVERSE,
      ST_REV_HOLD,
      ST_RET_STOP,
      ST_RET_SWITCH
   } fan_state_e;

endpackage

// [verilog/hydraulic_fan_valve_control.sv]
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "fan_cfg.svh"

// Overview of operation
// - Drive a proportional speed command and a reverse direction command.
// - Four temperature channels plus one override channel, all normalized.
// - Proportional command follows the demand computed from the channels.
// - Reverse request moves the fan into reverse through the reverse valve.
// - Stop request returns control to the idle state from any mode.
// - Every logical input has its own inversion bit, cleared by default.
// - Each channel selects any source or none; none is the default.
// - Full-scale input maps to the maximum temperature, default 120 degrees.
// - Zero input maps to the minimum temperature, default 20 degrees.
// - At or above the high threshold, default 100, demand full speed.
// - At or below the low threshold, default 80, demand minimum speed.
// - Idle means both proportional and reverse commands switched off.
// - Reversing: close proportional valve, wait stop time, switch reverse.
// - After switching the reverse valve, wait switch time, then reopen.
// - After the reverse request drops, keep reversing for the hold time.
module hydraulic_fan_valve_control
   import fan_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
)
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   // Logical outputs of other blocks, available as sources
   input wire logic [`N_SRC-1:0][`NORM_W-1:0] src_value_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Valve commands
   output norm_t prop_cmd_out,
   output logic rev_cmd_out
);

   // Pick a source from the bus; unconnected reads as zero
   function automatic norm_t pick_value(
      input logic [`N_SRC-1:0][`NORM_W-1:0] bus,
      input src_cfg_t cfg
   );
      logic [`CFG_SRC_W-1:0] sel;
      norm_t v;
      sel = cfg[`CFG_SRC_LSB +: `CFG_SRC_W];
      v = `NORM_ZERO;
      if (sel != 4'h0 && sel <= 4'(`N_SRC)) begin
         v = bus[3'(sel - 4'h1)];
         if (cfg[`CFG_INV_BIT]) begin
            v = ~v;
         end
      end
      return v;
   endfunction

   // A source selection of zero or beyond the bus is not connected
   function automatic logic is_connected(input src_cfg_t cfg);
      logic [`CFG_SRC_W-1:0] sel;
      sel = cfg[`CFG_SRC_LSB +: `CFG_SRC_W];
      return (sel != 4'h0 && sel <= 4'(`N_SRC));
   endfunction

   function automatic norm_t max16(input norm_t a, input norm_t b);
      return (a > b) ? a : b;
   endfunction
   // Configuration and setpoint storage
   src_cfg_t cfg_q [`N_CFG];
   temp_t sp_q [4*`N_TEMP];
   logic [15:0] t_stop_q;
   logic [15:0] t_switch_q;
   logic [15:0] t_hold_q;
   logic [31:0] rdata_q;
   // Selected inputs and derived demand
   norm_t chan_val_q [`N_TEMP];
   logic chan_conn_q [`N_TEMP];
   norm_t ovr_val_q;
   logic rev_req_q;
   logic stop_req_q;
   norm_t demand [`N_TEMP];
   norm_t peak_d;
   norm_t peak_q;
   // Sequencer
   fan_state_e state_q;
   fan_state_e state_d;
   logic [`TICK_CNT_W-1:0] tick_cnt_q;
   logic tick;
   logic [15:0] elapsed_q;
   logic [15:0] limit;
   logic time_done;
   norm_t prop_q;
   logic rev_q;

   logic [7:0] cfg_top;
   logic [7:0] sp_top;
   logic [7:0] dm_top;
   assign cfg_top = `ADDR_CFG_BASE + 8'(`N_CFG);
   assign sp_top = `ADDR_SP_BASE + 8'(4*`N_TEMP);
   assign dm_top = `ADDR_DEMAND_BASE + 8'(`N_TEMP);

   // Input configuration writes
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < `N_CFG; i++) begin
            cfg_q[i] <= `CFG_RESET;
         end
      end else if (reg_wr_in && reg_addr_in < cfg_top) begin
         cfg_q[3'(reg_addr_in - `ADDR_CFG_BASE)] <= reg_wdata_in[4:0];
      end
   end

   // Temperature setpoint writes; ordering is software's duty
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int c = 0; c < `N_TEMP; c++) begin
            sp_q[4*c + 0] <= `TMAX_RESET;
            sp_q[4*c + 1] <= `THIGH_RESET;
            sp_q[4*c + 2] <= `TLOW_RESET;
            sp_q[4*c + 3] <= `TMIN_RESET;
         end
      end else if (reg_wr_in && reg_addr_in >= `ADDR_SP_BASE &&
                   reg_addr_in < sp_top) begin
         sp_q[4'(reg_addr_in - `ADDR_SP_BASE)] <= reg_wdata_in[15:0];
      end
   end

   // Sequence time writes, tenths of a second
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         t_stop_q <= `T_STOP_RESET;
         t_switch_q <= `T_SWITCH_RESET;
         t_hold_q <= `T_HOLD_RESET;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `ADDR_T_STOP) begin
            t_stop_q <= reg_wdata_in[15:0];
         end
         if (reg_addr_in == `ADDR_T_SWITCH) begin
            t_switch_q <= reg_wdata_in[15:0];
         end
         if (reg_addr_in == `ADDR_T_HOLD) begin
            t_hold_q <= reg_wdata_in[15:0];
         end
      end
   end

   // Register every selected input once, so all logic sees one sample
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int c = 0; c < `N_TEMP; c++) begin
            chan_val_q[c] <= `NORM_ZERO;
            chan_conn_q[c] <= 1'b0;
         end
         ovr_val_q <= `NORM_ZERO;
         rev_req_q <= 1'b0;
         stop_req_q <= 1'b0;
      end else begin
         for (int c = 0; c < `N_TEMP; c++) begin
            chan_val_q[c] <= pick_value(src_value_in, cfg_q[c]);
            chan_conn_q[c] <= is_connected(cfg_q[c]);
         end
         ovr_val_q <= pick_value(src_value_in, cfg_q[`CFG_IDX_OVR]);
         // Logical inputs are true in the upper half of the scale
         rev_req_q <= pick_value(src_value_in,
            cfg_q[`CFG_IDX_REV]) >= 16'h8000;
         stop_req_q <= pick_value(src_value_in,
            cfg_q[`CFG_IDX_STOP]) >= 16'h8000;
      end
   end

   // One scaling and speed-window unit per temperature channel
   for (genvar g = 0; g < `N_TEMP; g++) begin : g_chan
      fan_channel u_chan (
         .sys_clk_in(sys_clk_in),
         .reset_n_in(reset_n_in),
         .norm_in(chan_val_q[g]),
         .conn_in(chan_conn_q[g]),
         .t_max_in(sp_q[4*g + 0]),
         .t_high_in(sp_q[4*g + 1]),
         .t_low_in(sp_q[4*g + 2]),
         .t_min_in(sp_q[4*g + 3]),
         .demand_out(demand[g])
      );
   end

   // Highest demand wins; the override joins as one more candidate
   always_comb begin
      peak_d = ovr_val_q;
      for (int c = 0; c < `N_TEMP; c++) begin
         peak_d = max16(peak_d, demand[c]);
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         peak_q <= `NORM_ZERO;
      end else begin
         peak_q <= peak_d;
      end
   end

   // Tenth-of-a-second tick; sequence times are within one tick
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tick_cnt_q <= '0;
      end else if (tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
      end
   end
   assign tick = (tick_cnt_q == `TICK_CNT_W'(TICK_CYCLES - 1));

   // Time limit of the current waiting state
   always_comb begin
      unique case (state_q)
         ST_REV_STOP, ST_RET_STOP: limit = t_stop_q;
         ST_REV_SWITCH, ST_RET_SWITCH: limit = t_switch_q;
         ST_REV_HOLD: limit = t_hold_q;
         ST_IDLE, ST_FORWARD, ST_REVERSE: limit = 16'h0000;
      endcase
   end
   assign time_done = (elapsed_q >= limit);

   // Elapsed ticks since the state was entered
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         elapsed_q <= 16'h0000;
      end else if (state_d != state_q) begin
         elapsed_q <= 16'h0000;
      end else if (tick && !time_done) begin
         elapsed_q <= elapsed_q + 16'h0001;
      end
   end

   // Reverse sequence; stop overrides every state
   always_comb begin
      state_d = state_q;
      if (stop_req_q) begin
         state_d = ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: state_d = ST_FORWARD;
            ST_FORWARD: begin
               if (rev_req_q) begin
                  state_d = ST_REV_STOP;
               end
            end
            ST_REV_STOP: begin
               if (time_done) begin
                  state_d = ST_REV_SWITCH;
               end
            end
            ST_REV_SWITCH: begin
               if (time_done) begin
                  state_d = ST_REVERSE;
               end
            end
            ST_REVERSE: begin
               if (!rev_req_q) begin
                  state_d = ST_REV_HOLD;
               end
            end
            ST_REV_HOLD: begin
               if (rev_req_q) begin
                  state_d = ST_REVERSE;
               end else if (time_done) begin
                  state_d = ST_RET_STOP;
               end
            end
            ST_RET_STOP: begin
               if (time_done) begin
                  state_d = ST_RET_SWITCH;
               end
            end
            ST_RET_SWITCH: begin
               if (time_done) begin
                  state_d = ST_FORWARD;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Valve commands from flops; speed is cut while a valve switches
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         prop_q <= `NORM_ZERO;
         rev_q <= 1'b0;
      end else begin
         unique case (state_d)
            ST_IDLE: begin
               prop_q <= `NORM_ZERO;
               rev_q <= 1'b0;
            end
            ST_FORWARD: begin
               prop_q <= peak_q;
               rev_q <= 1'b0;
            end
            ST_REV_STOP: begin
               prop_q <= `NORM_ZERO;
               rev_q <= 1'b0;
            end
            ST_REV_SWITCH: begin
               prop_q <= `NORM_ZERO;
               rev_q <= 1'b1;
            end
            ST_REVERSE, ST_REV_HOLD: begin
               prop_q <= peak_q;
               rev_q <= 1'b1;
            end
            ST_RET_STOP: begin
               prop_q <= `NORM_ZERO;
               rev_q <= 1'b1;
            end
            ST_RET_SWITCH: begin
               prop_q <= `NORM_ZERO;
               rev_q <= 1'b0;
            end
         endcase
      end
   end

   assign prop_cmd_out = prop_q;
   assign rev_cmd_out = rev_q;

   // Read data, valid only in the cycle after the strobe
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_q <= 32'h00000000;
      end else if (!reg_rd_in) begin
         rdata_q <= 32'h00000000;
      end else if (reg_addr_in < cfg_top) begin
         rdata_q <= 32'(cfg_q[3'(reg_addr_in - `ADDR_CFG_BASE)]);
      end else if (reg_addr_in >= `ADDR_SP_BASE && reg_addr_in < sp_top) begin
         rdata_q <= 32'(sp_q[4'(reg_addr_in - `ADDR_SP_BASE)]);
      end else if (reg_addr_in == `ADDR_T_STOP) begin
         rdata_q <= 32'(t_stop_q);
      end else if (reg_addr_in == `ADDR_T_SWITCH) begin
         rdata_q <= 32'(t_switch_q);
      end else if (reg_addr_in == `ADDR_T_HOLD) begin
         rdata_q <= 32'(t_hold_q);
      end else if (reg_addr_in == `ADDR_STATUS) begin
         rdata_q <= 32'(prop_q) | (32'(rev_q) << `ST_REV_BIT) |
                    (32'(state_q) << `ST_STATE_LSB);
      end else if (reg_addr_in >= `ADDR_DEMAND_BASE &&
                   reg_addr_in < dm_top) begin
         rdata_q <= 32'(demand[2'(reg_addr_in - `ADDR_DEMAND_BASE)]);
      end else begin
         rdata_q <= 32'h00000000; // Unmapped reads return zero
      end
   end

   assign reg_rdata_out = rdata_q;

endmodule
